// File: core/mode_seq_pkg.sv
// Package for the operating-mode sequencer: states, timing, carriers.
// Assumes a single 40 MHz clock domain.
package mode_seq_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned STARTUP_MS      = 10;
  localparam int unsigned SOFTSTART_MS    = 10;
  localparam int unsigned STARTUP_CYCLES  = (CLK_HZ / 1000) * STARTUP_MS;
  localparam int unsigned SOFTSTART_CYCLES = (CLK_HZ / 1000) * SOFTSTART_MS;
  localparam int unsigned TIMER_W         = 20;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic ACTIVE_REQ_RESET = 1'b0;
  localparam logic BOOST_EN_RESET   = 1'b0;

  // ---------------------------------------------------------------
  // Modes
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    MODE_RESET   = 5'h01,
    MODE_STANDBY = 5'h02,
    MODE_STARTUP = 5'h04,
    MODE_BOOST   = 5'h08,
    MODE_NORMAL  = 5'h10
  } mode_t;

  // Control register write carrier.
  typedef struct packed {
    logic wr;
    logic active_operation_request_bit;
    logic boost_enable_bit;
  } ctrl_wr_t;

  // Enables driven into the analog blocks.
  typedef struct packed {
    logic ref_osc_on;
    logic chip_enable;
    logic boost_on;
    logic boost_low_current;
  } enables_t;

endpackage

// File: core/power_mode_sequencer.sv
// Operating-mode sequencer: reset, standby, startup, boost startup, normal.
// Assumes all inputs synchronous to clk; writes arrive as one-cycle pulses.
//
// What this block does
// R1 - Reset pin low or power-on reset forces reset mode and defaults.
// R2 - Power-on reset follows second supply; on release go to standby.
// R3 - Active request bit defaults to zero after power-on reset.
// R4 - With active request zero and no reset, stay in standby.
// R5 - Writes accepted in standby; bits take effect after startup.
// R6 - Setting active request runs startup with a 10 ms oscillator delay.
// R7 - Over-temperature disables operation and holds startup until cleared.
// R8 - Boost startup runs low-current PWM for a 10 ms soft-start.
// R9 - Boost startup entered from startup or when boost enable set.
// R10 - Normal mode accepts any write order and any bits changed.
// R11 - Boost enable zero puts boost converter into standby.
// R12 - After startup delay with boost enable zero, or after soft-start delay, proceed to normal mode.
`timescale 1ns/1ps

module power_mode_sequencer
  import mode_seq_pkg::*;
#(
  parameter int unsigned STARTUP_LEN   = STARTUP_CYCLES,
  parameter int unsigned SOFTSTART_LEN = SOFTSTART_CYCLES
)
(
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire logic     external_reset_low_pin_n,
  input  wire logic     por_active,
  input  wire logic     overtemperature_cutoff,
  input  wire ctrl_wr_t ctrl_wr,
  output mode_t         mode,
  output enables_t      enables,
  output logic          active_req_out,
  output logic          boost_en_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  mode_t              mode_reg;
  mode_t              mode_next;
  logic               act_reg;
  logic               act_next;
  logic               bst_reg;
  logic               bst_next;
  logic [TIMER_W-1:0] tmr_reg;
  logic [TIMER_W-1:0] tmr_next;
  enables_t           en_reg;
  enables_t           en_next;
  logic               in_reset;

  localparam logic [TIMER_W-1:0] STARTUP_LOAD   = TIMER_W'(STARTUP_LEN - 1);
  localparam logic [TIMER_W-1:0] SOFTSTART_LOAD = TIMER_W'(SOFTSTART_LEN - 1);

  // R1 reset condition
  // R2 power-on reset input
  assign in_reset = !external_reset_low_pin_n || por_active;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    mode_next = mode_reg;
    act_next  = act_reg;
    bst_next  = bst_reg;
    tmr_next  = tmr_reg;
    // R5 writes in standby
    // R10 any order writes
    if (ctrl_wr.wr) begin
      act_next = ctrl_wr.active_operation_request_bit;
      bst_next = ctrl_wr.boost_enable_bit;
    end
    case (mode_reg)
      MODE_RESET: begin
        // R2 release to standby
        mode_next = MODE_STANDBY;
      end
      MODE_STANDBY: begin
        // R4 stay in standby
        // R6 start sequence
        if (act_reg) begin
          mode_next = MODE_STARTUP;
          tmr_next  = STARTUP_LOAD;
        end
      end
      MODE_STARTUP: begin
        // R7 hold while hot
        if (overtemperature_cutoff) begin
          tmr_next = STARTUP_LOAD;
        end else if (tmr_reg != '0) begin
          // R6 oscillator delay
          tmr_next = tmr_reg - TIMER_W'(1);
        end else if (bst_reg) begin
          // R9 boost from startup
          mode_next = MODE_BOOST;
          tmr_next  = SOFTSTART_LOAD;
        end else begin
          // R12 go normal
          mode_next = MODE_NORMAL;
        end
      end
      MODE_BOOST: begin
        if (overtemperature_cutoff) begin
          mode_next = MODE_STARTUP;
          tmr_next  = STARTUP_LOAD;
        end else if (!bst_reg) begin
          // R11 boost off, back to normal
          mode_next = MODE_NORMAL;
        end else if (tmr_reg != '0) begin
          // R8 soft-start delay
          tmr_next = tmr_reg - TIMER_W'(1);
        end else begin
          // R12 soft-start done
          mode_next = MODE_NORMAL;
        end
      end
      MODE_NORMAL: begin
        if (overtemperature_cutoff) begin
          mode_next = MODE_STARTUP;
          tmr_next  = STARTUP_LOAD;
        end else if (bst_reg && !en_reg.boost_on) begin
          // R9 boost from normal
          mode_next = MODE_BOOST;
          tmr_next  = SOFTSTART_LOAD;
        end
      end
      default: begin
        mode_next = MODE_RESET;
      end
    endcase
    if (!act_reg && mode_reg != MODE_RESET) begin
      // R4 back to standby
      mode_next = MODE_STANDBY;
      tmr_next  = '0;
    end
    // R1 defaults on reset
    // R3 request defaults low
    if (in_reset) begin
      mode_next = MODE_RESET;
      act_next  = ACTIVE_REQ_RESET;
      bst_next  = BOOST_EN_RESET;
      tmr_next  = '0;
    end
  end

  // ---------------------------------------------------------------
  // Enables
  // ---------------------------------------------------------------
  always_comb begin
    en_next = '0;
    case (mode_next)
      MODE_STARTUP: begin
        en_next.ref_osc_on = 1'b1;
      end
      MODE_BOOST: begin
        en_next.ref_osc_on        = 1'b1;
        en_next.chip_enable       = 1'b1;
        // R8 low-current PWM
        en_next.boost_on          = 1'b1;
        en_next.boost_low_current = 1'b1;
      end
      MODE_NORMAL: begin
        en_next.ref_osc_on  = 1'b1;
        en_next.chip_enable = 1'b1;
        // R11 boost follows bit
        en_next.boost_on    = bst_reg && bst_next && en_reg.boost_on;
      end
      default: begin
        en_next = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg <= MODE_RESET;
      act_reg  <= ACTIVE_REQ_RESET;
      bst_reg  <= BOOST_EN_RESET;
      tmr_reg  <= '0;
      en_reg   <= '0;
    end else begin
      mode_reg <= mode_next;
      act_reg  <= act_next;
      bst_reg  <= bst_next;
      tmr_reg  <= tmr_next;
      en_reg   <= en_next;
    end
  end

  assign mode           = mode_reg;
  assign enables        = en_reg;
  assign active_req_out = act_reg;
  assign boost_en_out   = bst_reg;

endmodule // power_mode_sequencer

// File: test/mode_seq_chk.sv
// Port checker for the operating-mode sequencer.
// Assumes it is bound to power_mode_sequencer.
`timescale 1ns/1ps
module mode_seq_chk
  import mode_seq_pkg::*;
(
  input wire logic     clk,
  input wire logic     rst,
  input wire logic     external_reset_low_pin_n,
  input wire logic     por_active,
  input wire logic     overtemperature_cutoff,
  input wire ctrl_wr_t ctrl_wr,
  input wire mode_t    mode,
  input wire enables_t enables,
  input wire logic     active_req_out,
  input wire logic     boost_en_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire rq = !external_reset_low_pin_n || por_active;
  wire hot = overtemperature_cutoff;
  wire wr = ctrl_wr.wr;
  a_reset_forces: assert property (rq |=> mode == MODE_RESET
    && !active_req_out && !boost_en_out) else $error("reset ignored");
  a_release_standby: assert property (mode == MODE_RESET && !rq
    |=> mode == MODE_STANDBY) else $error("no standby after reset");
  a_standby_rest: assert property (mode == MODE_STANDBY && !rq
    && !active_req_out && !wr |=> mode == MODE_STANDBY && enables == '0)
    else $error("standby left");
  a_write_taken: assert property (wr && !rq |=>
    active_req_out == $past(ctrl_wr.active_operation_request_bit)
    && boost_en_out == $past(ctrl_wr.boost_enable_bit))
    else $error("write lost");
  a_start_entry: assert property (mode == MODE_STANDBY && !rq
    && active_req_out && !wr |=> mode == MODE_STARTUP)
    else $error("no startup");
  a_osc_startup: assert property (mode == MODE_STARTUP
    |-> enables.ref_osc_on) else $error("oscillator off");
  a_heat_holds: assert property (hot && active_req_out && !rq && !wr
    && mode != MODE_STANDBY && mode != MODE_RESET |=> mode == MODE_STARTUP)
    else $error("heat not held");
  a_soft_start: assert property (mode == MODE_BOOST |->
    enables.boost_on && enables.boost_low_current) else $error("no soft");
  a_boost_idle: assert property ((mode == MODE_NORMAL
    && !boost_en_out)[*2] |-> !enables.boost_on) else $error("boost on");
  a_boost_from_norm: assert property (mode == MODE_NORMAL && !hot
    && boost_en_out && !enables.boost_on && active_req_out && !rq
    |=> mode == MODE_BOOST) else $error("no boost entry");
  a_boost_drop: assert property (mode == MODE_BOOST && !hot
    && !boost_en_out && active_req_out && !rq
    |=> mode == MODE_NORMAL && !enables.boost_on)
    else $error("boost not dropped");
  c_boost: cover property (mode == MODE_BOOST ##1 mode == MODE_NORMAL);
  c_norm_boost: cover property (mode == MODE_NORMAL ##1 mode == MODE_BOOST);
  c_startup: cover property (mode == MODE_STARTUP);
  c_heat: cover property (mode == MODE_STARTUP && hot);
  c_back: cover property (mode == MODE_STARTUP ##1 mode == MODE_STANDBY);
endmodule // mode_seq_chk
bind power_mode_sequencer mode_seq_chk u_mode_seq_chk (.*);

// File: test/tb.sv
// Bench for the mode sequencer: reset, standby, startup, heat hold.
// Assumes the package and the checker are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  failures++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
  import mode_seq_pkg::*;
  logic     clk = 0, rst = 1, pin_n = 1, por = 0, hot = 0, act, bst;
  ctrl_wr_t wr = '0;
  mode_t    mode;
  enables_t en;
  int       failures = 0, checks_done = 0, cyc = 0;
  localparam int unsigned ST_LEN = 40;
  localparam int unsigned SS_LEN = 30;
  always #12.5 clk = ~clk;
  power_mode_sequencer #(.STARTUP_LEN(ST_LEN), .SOFTSTART_LEN(SS_LEN))
    u_power_mode_sequencer (.clk(clk), .rst(rst),
    .external_reset_low_pin_n(pin_n), .por_active(por),
    .overtemperature_cutoff(hot), .ctrl_wr(wr), .mode(mode),
    .enables(en), .active_req_out(act), .boost_en_out(bst));
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic put(logic a, logic b);
    @(posedge clk) wr <= '{1'b1, a, b};
    @(posedge clk) wr <= '0;
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic t_boot();
    repeat (20) @(posedge clk);
    rst <= 0;
    tick(1);
    `CHK("mode", MODE_STANDBY, mode)
    `CHK("act", 1'b0, act)
    tick(5);
    `CHK("mode", MODE_STANDBY, mode)
    `CHK("en", 4'h0, en)
    $display("boot done");
  endtask
  task automatic t_start();
    put(1, 1);
    `CHK("act", 1'b1, act)
    `CHK("bst", 1'b1, bst)
    tick(1);
    `CHK("mode", MODE_STARTUP, mode)
    `CHK("osc", 1'b1, en.ref_osc_on)
    @(posedge clk) hot <= 1;
    tick(50);
    `CHK("mode", MODE_STARTUP, mode)
    `CHK("chip", 1'b0, en.chip_enable)
    @(posedge clk) hot <= 0;
    tick(ST_LEN - 1);
    `CHK("mode", MODE_STARTUP, mode)
    tick(1);
    `CHK("mode", MODE_BOOST, mode)
    `CHK("low", 1'b1, en.boost_low_current)
    tick(SS_LEN - 1);
    `CHK("mode", MODE_BOOST, mode)
    tick(1);
    `CHK("mode", MODE_NORMAL, mode)
    `CHK("en", 4'he, en)
    $display("startup done");
  endtask
  task automatic t_normal();
    put(1, 0);
    `CHK("bst", 1'b0, bst)
    `CHK("en", 4'hc, en)
    put(1, 1);
    tick(1);
    `CHK("mode", MODE_BOOST, mode)
    `CHK("en", 4'hf, en)
    put(1, 0);
    tick(1);
    `CHK("mode", MODE_NORMAL, mode)
    `CHK("en", 4'hc, en)
    @(posedge clk) hot <= 1;
    tick(1);
    `CHK("mode", MODE_STARTUP, mode)
    `CHK("en", 4'h8, en)
    @(posedge clk) hot <= 0;
    put(0, 0);
    tick(1);
    `CHK("mode", MODE_STANDBY, mode)
    `CHK("en", 4'h0, en)
    $display("normal done");
  endtask
  task automatic t_resets();
    put(1, 0);
    @(posedge clk) pin_n <= 0;
    tick(1);
    `CHK("mode", MODE_RESET, mode)
    `CHK("act", 1'b0, act)
    put(1, 1);
    `CHK("act", 1'b0, act)
    @(posedge clk) pin_n <= 1;
    por <= 1;
    tick(1);
    `CHK("mode", MODE_RESET, mode)
    @(posedge clk) por <= 0;
    tick(1);
    `CHK("mode", MODE_STANDBY, mode)
    $display("resets done");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 1000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    t_boot();
    t_start();
    t_normal();
    t_resets();
    print_verdict();
  end
endmodule // tb
